// ---- inc/dcc_pkg.sv ----
// constants and types for the converter code and mode control block
package dcc_pkg;
    localparam logic [11:0] ADDR_REF_CTRL = 12'h000;
    localparam logic [11:0] ADDR_MODE = 12'h004;
    localparam logic [11:0] ADDR_CODE_LOW = 12'h008;
    localparam logic [11:0] ADDR_CODE_HIGH = 12'h00C;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    localparam int REF_EN_POS = 4;
    localparam int LOW_MSB = 7;
    localparam int LOW_LSB = 6;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int CODE_W = 10;
    // full scale divisor and half reference as fixed point (numerator, divisor)
    localparam int SCALE_DIV = 1024;
    localparam int HALF_NUM = 1;
    localparam int HALF_DEN = 2;

    typedef enum logic [1:0] {
        DCC_REF_INT,
        DCC_REF_SUPPLY,
        DCC_REF_FLOAT
    } dcc_ref_src_t;

    typedef enum logic [1:0] {
        DCC_OUT_FLOAT,
        DCC_OUT_DRIVE,
        DCC_OUT_GROUND
    } dcc_out_mode_t;

    typedef struct packed {
        dcc_ref_src_t ref_src;
        logic ref_gen_on;
        dcc_out_mode_t out_mode;
        logic [CODE_W-1:0] code;
    } dcc_analog_ctrl_t;
endpackage : dcc_pkg

// ---- src/dcc_decode.sv ----
// field decode from register values to analog control word
`timescale 1ns/10ps
module dcc_decode (
    // register fields
    input wire logic [1:0] conv_ref_select,
    input wire logic ref_gen_enable,
    input wire logic [1:0] conv_mode_field,
    input wire logic [9:0] conv_code_bits,
    // decoded control
    output dcc_pkg::dcc_analog_ctrl_t ctrl
);
    always_comb begin
        unique case (conv_ref_select)
            2'h0, 2'h1: ctrl.ref_src = dcc_pkg::DCC_REF_INT;
            2'h2: ctrl.ref_src = dcc_pkg::DCC_REF_SUPPLY;
            2'h3: ctrl.ref_src = dcc_pkg::DCC_REF_FLOAT;
        endcase
        unique case (conv_mode_field)
            2'h0: ctrl.out_mode = dcc_pkg::DCC_OUT_FLOAT;
            2'h2: ctrl.out_mode = dcc_pkg::DCC_OUT_GROUND;
            2'h1, 2'h3: ctrl.out_mode = dcc_pkg::DCC_OUT_DRIVE;
        endcase
        ctrl.ref_gen_on = ref_gen_enable;
        ctrl.code = conv_code_bits;
    end
endmodule : dcc_decode

// ---- src/dcc_top.sv ----
// register front end of the 10-bit converter, apb slave
`timescale 1ns/10ps
module dcc_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter control
    output dcc_pkg::dcc_analog_ctrl_t analog_ctrl_r,
    // reference source is internal but generator is powered down
    output logic ref_missing_r
);
    logic [1:0] ref_sel_r;
    logic ref_en_r;
    logic [1:0] mode_r;
    logic [1:0] low_r;
    logic [7:0] high_r;
    logic [9:0] code_live_r;
    logic [9:0] code_nxt;
    logic wr_go;
    logic rd_go;
    logic hit;
    logic [31:0] rdata;
    dcc_pkg::dcc_analog_ctrl_t ctrl_nxt;

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == dcc_pkg::ADDR_REF_CTRL) || (a == dcc_pkg::ADDR_MODE) ||
                  (a == dcc_pkg::ADDR_CODE_LOW) || (a == dcc_pkg::ADDR_CODE_HIGH) ||
                  (a == dcc_pkg::ADDR_STATUS);
    endfunction : addr_ok

    // zero-wait slave: pready rises in the access phase; a write commits only at
    // the edge where the master sees pready, so an aborted setup changes nothing
    assign hit = addr_ok(paddr);
    assign wr_go = psel && penable && pready && pwrite && hit;
    assign rd_go = psel && !penable && !pwrite;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ref_sel_r <= 2'h0;
            ref_en_r <= 1'b0;
        end else if (wr_go && paddr == dcc_pkg::ADDR_REF_CTRL) begin
            ref_sel_r <= pwdata[1:0];
            ref_en_r <= pwdata[dcc_pkg::REF_EN_POS];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_r <= 2'h0;
        end else if (wr_go && paddr == dcc_pkg::ADDR_MODE) begin
            mode_r <= pwdata[1:0];
        end
    end

    // low bits are only staged; software loads them first
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            low_r <= 2'h0;
        end else if (wr_go && paddr == dcc_pkg::ADDR_CODE_LOW) begin
            low_r <= pwdata[dcc_pkg::LOW_MSB:dcc_pkg::LOW_LSB];
        end
    end

    assign code_nxt = {pwdata[7:0], low_r};

    // the live code changes only on the high write, never half updated
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            high_r <= dcc_pkg::RESET_VALUE;
            code_live_r <= 10'h000;
        end else if (wr_go && paddr == dcc_pkg::ADDR_CODE_HIGH) begin
            high_r <= pwdata[7:0];
            code_live_r <= code_nxt;
        end
    end

    // unimplemented bits read zero
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (paddr)
            dcc_pkg::ADDR_REF_CTRL: begin
                rdata[1:0] = ref_sel_r;
                rdata[dcc_pkg::REF_EN_POS] = ref_en_r;
            end
            dcc_pkg::ADDR_MODE: rdata[1:0] = mode_r;
            dcc_pkg::ADDR_CODE_LOW: rdata[dcc_pkg::LOW_MSB:dcc_pkg::LOW_LSB] = low_r;
            dcc_pkg::ADDR_CODE_HIGH: rdata[7:0] = high_r;
            dcc_pkg::ADDR_STATUS: rdata[9:0] = code_live_r;
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata <= rd_go ? rdata : 32'h0000_0000;
        end
    end

    dcc_decode u_decode (
        .conv_ref_select(ref_sel_r),
        .ref_gen_enable(ref_en_r),
        .conv_mode_field(mode_r),
        .conv_code_bits(code_live_r),
        .ctrl(ctrl_nxt)
    );

    // analog side sees registered control; scaling by half of reference over
    // 1024 steps is done by the resistor string driven from this word
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            analog_ctrl_r <= '{dcc_pkg::DCC_REF_INT, 1'b0, dcc_pkg::DCC_OUT_FLOAT, 10'h000};
            ref_missing_r <= 1'b1;
        end else begin
            analog_ctrl_r <= ctrl_nxt;
            ref_missing_r <= (ctrl_nxt.ref_src == dcc_pkg::DCC_REF_INT) && !ctrl_nxt.ref_gen_on;
        end
    end
endmodule : dcc_top

// ---- tb/dcc_top_bench.sv ----
// self-checking bench for the converter control block
`timescale 1ns/10ps
`define CHK(n, g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module dcc_top_bench;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, ref_missing_r;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rnd = 32'hDDDD, d;
    logic [32:0] exp_q[$], e;
    logic [9:0] c = 10'h000;
    logic [1:0] rs, om;
    dcc_pkg::dcc_analog_ctrl_t analog_ctrl_r;
    int mismatches = 0, n_tests = 0, cyc = 0;
    dcc_top dcc_top_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .analog_ctrl_r(analog_ctrl_r), .ref_missing_r(ref_missing_r));
    initial forever #20 clk_sys = ~clk_sys;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic complete_run();
        if (mismatches == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    // apb transfer; the expected {pslverr, prdata} is queued at setup
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
        input logic [32:0] x);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        exp_q.push_back(x);
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    always @(posedge clk_sys) begin
        if (pready === 1'b1) begin
            e = exp_q.pop_front();
            `CHK("answer", {pslverr, prdata}, e)
        end
        if (++cyc == 4000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        `CHK("reset", {analog_ctrl_r, ref_missing_r}, {15'h0, 1'b1})
        for (int a = 0; a <= 20; a += 4) xfer(1'b0, a[11:0], '0, {a > 16, 32'h0});
        xfer(1'b1, 12'h014, rnd, {1'b1, 32'h0});
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            if (i == 15) rnd = 32'hFFFFFFFF;
            d = {rnd[31:4], i[3:0]};
            rs = d[1] ? (d[0] ? 2'h2 : 2'h1) : 2'h0;
            om = d[0] ? 2'h1 : {d[1], 1'b0};
            xfer(1'b1, 12'h000, d, '0);
            xfer(1'b1, 12'h004, d, '0);
            xfer(1'b0, 12'h000, '0, {25'h0, d[7:0] & 8'h13});
            xfer(1'b0, 12'h004, '0, {31'h0, d[1:0]});
            xfer(1'b1, 12'h008, rnd, '0);
            repeat (2) @(posedge clk_sys);
            `CHK("staged", analog_ctrl_r.code, c)
            xfer(1'b1, 12'h00C, rnd >> 8, '0);
            xfer(1'b0, 12'h008, '0, {25'h0, rnd[7:6], 6'h0});
            xfer(1'b0, 12'h00C, '0, {25'h0, rnd[15:8]});
            xfer(1'b0, 12'h010, '0, {23'h0, rnd[15:8], rnd[7:6]});
            c = {rnd[15:8], rnd[7:6]};
            repeat (2) @(posedge clk_sys);
            `CHK("ctrl", {analog_ctrl_r, ref_missing_r}, {rs, d[4], om, c, rs == 2'h0 && !d[4]})
        end
        complete_run();
    end
endmodule : dcc_top_bench

// ---- tb/dcc_top_chk.sv ----
// assertion checker for the converter control block
`timescale 1ns/10ps
module dcc_chk (
    // watched ports
    input wire logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, ref_missing_r,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire dcc_pkg::dcc_analog_ctrl_t analog_ctrl_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire setup = psel && !penable;
    // a write commits at the access edge, where the master samples pready
    wire acc = psel && penable && pready;
    wire wr_hi = acc && pwrite && paddr == 12'h00C;
    rdy_next_a: assert property (setup |=> pready) else $error("ready late");
    rdy_only_a: assert property (pready |-> penable && $past(setup)) else $error("stray ready");
    code_load_a: assert property (wr_hi |=> ##1 analog_ctrl_r.code[9:2] == $past(pwdata[7:0], 2))
        else $error("code high");
    code_hold_a: assert property ($changed(analog_ctrl_r.code) |-> $past(wr_hi, 2))
        else $error("code moved");
    ref_sel_a: assert property (acc && pwrite && paddr == 12'h000 |=> ##1
        analog_ctrl_r.ref_src == ($past(pwdata[1], 2) ? 2'h1 + $past(pwdata[0], 2) : 2'h0))
        else $error("ref source");
    gen_en_a: assert property (acc && pwrite && paddr == 12'h000 |=> ##1
        analog_ctrl_r.ref_gen_on == $past(pwdata[4], 2)) else $error("gen enable");
    mode_sel_a: assert property (acc && pwrite && paddr == 12'h004 |=> ##1
        analog_ctrl_r.out_mode == ($past(pwdata[0], 2) ? 2'h1 : {$past(pwdata[1], 2), 1'b0}))
        else $error("mode");
    err_map_a: assert property (pready |-> pslverr == !(paddr[1:0] == 2'h0 && paddr <= 12'h010))
        else $error("slverr");
    rd_pad_a: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata[31:2] == 30'h0)
        else $error("mode pad");
    ref_miss_a: assert property (ref_missing_r ==
        (analog_ctrl_r.ref_src == 2'h0 && !analog_ctrl_r.ref_gen_on)) else $error("ref missing");
endmodule : dcc_chk
bind dcc_top dcc_chk dcc_chk_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .ref_missing_r(ref_missing_r),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .analog_ctrl_r(analog_ctrl_r));
